/* File: verilog/u2_uart.sv */
// second serial port: baud timer, transmitter, receiver, registers
`timescale 1ns/1ps
`default_nettype none
`include "u2_map.svh"
module u2_uart import u2_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic extended_uart_enable,
    input wire logic serial_receive_pin,
    output logic [7:0] sfr_rdata,
    output logic serial_transmit_pin
);
    logic [7:0] uart2_control_status;
    logic [7:0] uart2_baud_control;
    logic [7:0] rx_hold;
    logic wr_ctl, wr_data, wr_baud;
    assign wr_ctl = sfr_wr && sfr_addr == `U2_ADDR_CONTROL;
    assign wr_data = sfr_wr && sfr_addr == `U2_ADDR_DATA;
    assign wr_baud = sfr_wr && sfr_addr == `U2_ADDR_BAUD;

    // baud timer: prescale 2^(div+ext), fractional accumulator over 64 steps
    logic [9:0] pre_cnt;
    logic [3:0] shift;
    logic [6:0] frac;
    logic [6:0] frac_acc;
    logic [7:0] frac_sum;
    logic pre_tick, tick16;
    assign shift = {1'b0, uart2_baud_control[2:0]} + {2'b00, uart2_baud_control[4:3]};
    assign frac = uart2_baud_control[`U2_BIT_FSEL] ? `U2_FRAC_SET : `U2_FRAC_CLR;
    // >= so a divider lowered mid-count ticks at once instead of wrapping
    assign pre_tick = pre_cnt >= ((10'h001 << shift) - 10'h001);
    assign frac_sum = {1'b0, frac_acc} + {1'b0, frac};
    // x16 tick: one prescale tick per output, with the next prescale tick swallowed when the fraction wraps
    logic frac_pend;
    always_ff @(posedge clk) begin
        if (reset) begin
            pre_cnt <= 10'h000;
            frac_acc <= 7'h00;
            frac_pend <= 1'b0;
            tick16 <= 1'b0;
        end else if (clk_en) begin
            tick16 <= 1'b0;
            if (pre_tick) begin
                pre_cnt <= 10'h000;
                if (frac_pend) begin
                    frac_pend <= 1'b0; // a swallowed tick stretches the period by frac/64
                end else begin
                    tick16 <= 1'b1;
                    if (frac_sum >= {1'b0, `U2_FRAC_ONE}) begin
                        frac_acc <= frac_sum[6:0] - `U2_FRAC_ONE;
                        frac_pend <= 1'b1;
                    end else begin
                        frac_acc <= frac_sum[6:0];
                    end
                end
            end else begin
                pre_cnt <= pre_cnt + 10'h001;
            end
        end
    end

    // two-entry buffer between data register writes and the shifter
    u2_word_t buf_q [0:1];
    logic buf_wp, buf_rp;
    logic [1:0] buf_cnt;
    logic buf_ready, buf_valid, tx_take;
    assign buf_ready = buf_cnt != 2'd2;
    assign buf_valid = buf_cnt != 2'd0;
    always_ff @(posedge clk) begin
        if (reset) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'd0;
        end else if (clk_en) begin
            // a write while both entries are full is dropped
            if (wr_data && buf_ready) begin
                buf_q[buf_wp] <= '{data: sfr_wdata, ninth: uart2_baud_control[`U2_BIT_TX9]};
                buf_wp <= ~buf_wp;
            end
            if (tx_take) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, wr_data && buf_ready} - {1'b0, tx_take};
        end
    end

    // transmitter
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_sub;
    logic tx_busy;
    assign tx_take = buf_valid && !tx_busy;
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_shift <= 11'h7FF;
            tx_bits <= 4'd0;
            tx_sub <= 4'h0;
            tx_busy <= 1'b0;
            serial_transmit_pin <= 1'b1;
        end else if (clk_en) begin
            if (tx_take) begin
                // start, data LSB first, ninth bit, stop
                tx_shift <= uart2_control_status[`U2_BIT_NINE] ?
                    {1'b1, buf_q[buf_rp].ninth, buf_q[buf_rp].data, 1'b0} :
                    {2'b11, buf_q[buf_rp].data, 1'b0};
                tx_bits <= uart2_control_status[`U2_BIT_NINE] ? 4'd11 : 4'd10;
                tx_sub <= 4'h0;
                tx_busy <= 1'b1;
            end else if (tx_busy && tick16) begin
                serial_transmit_pin <= tx_shift[0];
                tx_sub <= tx_sub + 4'h1;
                if (tx_sub == `U2_OVERSAMPLE) begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_bits <= tx_bits - 4'd1;
                    if (tx_bits == 4'd1) begin
                        tx_busy <= 1'b0;
                    end
                end
            end
        end
    end
    // flag at the end of the eighth data bit, ahead of any ninth bit and the stop
    logic tx_done_ev;
    assign tx_done_ev = tx_busy && tick16 && tx_sub == `U2_OVERSAMPLE &&
        tx_bits == (uart2_control_status[`U2_BIT_NINE] ? 4'd3 : 4'd2);

    // receive pin: three flops, a change counts once the last two agree
    logic [2:0] rx_sync;
    logic rx_line, rx_line_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_sync <= 3'b111;
            rx_line <= 1'b1;
            // previous level resets to idle high, so release gives no false edge
            rx_line_q <= 1'b1;
        end else if (clk_en) begin
            rx_sync <= {rx_sync[1:0], serial_receive_pin};
            rx_line_q <= rx_line;
            if (rx_sync[2] == rx_sync[1]) begin
                rx_line <= rx_sync[2];
            end
        end
    end

    // receiver
    u2_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic rx_done, rx_stop_ok;
    logic [7:0] low_ticks;
    logic low_long, break_ev;
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state <= U2_RX_IDLE;
            rx_sub <= 4'h0;
            rx_bits <= 4'd0;
            rx_shift <= 9'h000;
            rx_done <= 1'b0;
            rx_stop_ok <= 1'b0;
        end else if (clk_en) begin
            rx_done <= 1'b0;
            unique case (rx_state)
                U2_RX_IDLE: begin
                    // a start needs a 1-to-0 edge, so a line held low cannot restart
                    if (rx_line_q && !rx_line &&
                        uart2_control_status[`U2_BIT_REN]) begin
                        rx_state <= U2_RX_START;
                        rx_sub <= 4'h0;
                    end
                end
                U2_RX_START: begin
                    if (tick16) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == `U2_MID_SAMPLE) begin
                            rx_sub <= 4'h0;
                            rx_bits <= uart2_control_status[`U2_BIT_NINE] ? 4'd9 : 4'd8;
                            rx_state <= rx_line ? U2_RX_IDLE : U2_RX_DATA;
                        end
                    end
                end
                U2_RX_DATA: begin
                    if (tick16) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == `U2_OVERSAMPLE) begin
                            // LSB first into the top, 8 or 9 bits
                            rx_shift <= {rx_line, rx_shift[8:1]};
                            rx_bits <= rx_bits - 4'd1;
                            if (rx_bits == 4'd1) begin
                                rx_state <= U2_RX_STOP;
                            end
                        end
                    end
                end
                U2_RX_STOP: begin
                    if (tick16) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == `U2_OVERSAMPLE) begin
                            rx_stop_ok <= rx_line;
                            rx_done <= 1'b1;
                            rx_state <= U2_RX_IDLE;
                        end
                    end
                end
                default: rx_state <= U2_RX_IDLE;
            endcase
        end
    end

    // break: line low for the length of start, eight data, parity, half stop
    always_ff @(posedge clk) begin
        if (reset) begin
            low_ticks <= 8'h00;
            low_long <= 1'b0;
            break_ev <= 1'b0;
        end else if (clk_en) begin
            if (rx_line) begin
                low_ticks <= 8'h00;
            end else if (tick16 && low_ticks != `U2_BREAK_TICKS) begin
                low_ticks <= low_ticks + 8'h01;
            end
            break_ev <= 1'b0;
            if (rx_state == U2_RX_IDLE && rx_line) begin
                low_long <= 1'b0;
            end else if (low_ticks == `U2_BREAK_TICKS) begin
                low_long <= 1'b1;
                // in 8-bit mode the threshold lies past the stop sample, so the flag rises late
                break_ev <= !low_long;
            end
        end
    end

    // data byte taken from the upper eight bits of the shifter in 8-bit mode
    logic [7:0] rx_byte;
    logic rx_ninth, rx_accept;
    assign rx_byte = uart2_control_status[`U2_BIT_NINE] ? rx_shift[7:0] : rx_shift[8:1];
    assign rx_ninth = uart2_control_status[`U2_BIT_NINE] ? rx_shift[8] : rx_stop_ok;
    assign rx_accept = rx_done && (extended_uart_enable ||
        !uart2_control_status[`U2_BIT_RI]);

    // registers; hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            uart2_control_status <= `U2_CONTROL_RESET;
            uart2_baud_control <= `U2_BAUD_RESET;
            rx_hold <= 8'h00;
        end else if (clk_en) begin
            if (wr_ctl) begin
                uart2_control_status[`U2_BIT_NINE] <= sfr_wdata[`U2_BIT_NINE];
                uart2_control_status[`U2_BIT_REN] <= sfr_wdata[`U2_BIT_REN];
                uart2_control_status[`U2_BIT_TI] <= sfr_wdata[`U2_BIT_TI];
                uart2_control_status[`U2_BIT_RI] <= sfr_wdata[`U2_BIT_RI];
                if (!sfr_wdata[`U2_BIT_OWE]) begin
                    uart2_control_status[`U2_BIT_OWE] <= 1'b0;
                end
            end
            if (wr_baud) begin
                uart2_baud_control[7] <= sfr_wdata[7];
                uart2_baud_control[5:0] <= sfr_wdata[5:0];
            end
            if (tx_done_ev) begin
                uart2_control_status[`U2_BIT_TI] <= 1'b1;
            end
            if (rx_done) begin
                uart2_control_status[`U2_BIT_FE] <= !rx_stop_ok;
                uart2_control_status[`U2_BIT_BE] <= low_long;
            end
            if (break_ev) begin
                uart2_control_status[`U2_BIT_BE] <= 1'b1;
            end
            if (rx_accept) begin
                rx_hold <= rx_byte;
                uart2_baud_control[`U2_BIT_RX9] <= rx_ninth;
                uart2_control_status[`U2_BIT_RI] <= 1'b1;
                if (uart2_control_status[`U2_BIT_RI]) begin
                    uart2_control_status[`U2_BIT_OWE] <= 1'b1;
                end
            end
        end
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en) begin
            if (!sfr_rd) begin
                sfr_rdata <= sfr_rdata;
            end else if (sfr_addr == `U2_ADDR_CONTROL) begin
                sfr_rdata <= {1'b0, uart2_control_status[6:0]};
            end else if (sfr_addr == `U2_ADDR_DATA) begin
                sfr_rdata <= rx_hold;
            end else if (sfr_addr == `U2_ADDR_BAUD) begin
                sfr_rdata <= uart2_baud_control;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/u2_map.svh */
// register offsets, field positions, reset values and timing counts of the second serial port
`ifndef U2_MAP_SVH
`define U2_MAP_SVH
`define U2_ADDR_CONTROL 8'hE1
`define U2_ADDR_DATA 8'hEB
`define U2_ADDR_BAUD 8'hEE
`define U2_BIT_NINE 6
`define U2_BIT_OWE 5
`define U2_BIT_FE 4
`define U2_BIT_BE 3
`define U2_BIT_REN 2
`define U2_BIT_TI 1
`define U2_BIT_RI 0
`define U2_BIT_TX9 7
`define U2_BIT_RX9 6
`define U2_BIT_FSEL 5
`define U2_FRAC_SET 7'h2B
`define U2_FRAC_CLR 7'h07
`define U2_FRAC_ONE 7'h40
`define U2_CONTROL_RESET 8'h00
`define U2_BAUD_RESET 8'h00
`define U2_OVERSAMPLE 4'hF
`define U2_MID_SAMPLE 4'h7
`define U2_BREAK_TICKS 8'hA8
`endif

/* File: verilog/u2_pkg.sv */
// types of the second serial port
package u2_pkg;
    typedef enum logic [3:0] {
        U2_RX_IDLE = 4'h1,
        U2_RX_START = 4'h2,
        U2_RX_DATA = 4'h4,
        U2_RX_STOP = 4'h8
    } u2_rx_state_t;
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } u2_word_t;
endpackage

/* File: bench/u2_uart_properties.sv */
// concurrent checks on the pins and register bus of the second serial port
`timescale 1ns/1ps
`default_nettype none
module u2_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic extended_uart_enable,
    input wire logic serial_receive_pin,
    input wire logic [7:0] sfr_rdata,
    input wire logic serial_transmit_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    AST_RESET_IDLE: assert property ($fell(reset) && $past(clk_en) |->
        serial_transmit_pin && sfr_rdata == 8'h00) else $error("port not idle after reset");
    AST_RDATA_HOLD: assert property (!(clk_en && sfr_rd) |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (clk_en && sfr_rd &&
        !(sfr_addr inside {8'hE1, 8'hEB, 8'hEE}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_WR: assert property (clk_en && sfr_wr && sfr_addr == 8'hE1 ##2
        clk_en && sfr_rd && sfr_addr == 8'hE1 |=>
        (sfr_rdata & 8'hC4) == ($past(sfr_wdata, 3) & 8'h44)) else $error("control readback");
    AST_BAUD_WR: assert property (clk_en && sfr_wr && sfr_addr == 8'hEE ##2
        clk_en && sfr_rd && sfr_addr == 8'hEE |=>
        (sfr_rdata & 8'hBF) == ($past(sfr_wdata, 3) & 8'hBF)) else $error("baud readback");
    // a frozen clock enable must stop the bit timer and the bus alike
    AST_FREEZE: assert property (!clk_en |=>
        $stable(serial_transmit_pin) && $stable(sfr_rdata)) else $error("state moved while frozen");
    // one bit lasts 16 ticks and a tick is never shorter than a clock
    AST_BIT_LOW: assert property ($fell(serial_transmit_pin) |->
        !serial_transmit_pin [*8]) else $error("low bit too short");
    AST_BIT_HIGH: assert property ($rose(serial_transmit_pin) |->
        serial_transmit_pin [*8]) else $error("high bit too short");
endmodule
`default_nettype wire

/* File: bench/u2_remote.sv */
// far-end serial transceiver model: frame sender and frame decoder
`timescale 1ns/1ps
`default_nettype none
module u2_remote (
    input wire logic tx_line,
    input wire logic nine,
    output logic rx_line
);
    real bit_ns = 443.75;
    real t_fall = 0.0;
    real low_ns = 0.0;
    logic [8:0] got_q[$];
    logic got_stop = 1'b0;
    initial rx_line = 1'b1; // pulled-up idle line
    task automatic send(input logic [7:0] d, input logic n9, input logic stop, input int extra);
        rx_line = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++) begin
            rx_line = d[i];
            #(bit_ns);
        end
        if (nine) begin
            rx_line = n9;
            #(bit_ns);
        end
        rx_line = stop;
        #(bit_ns * (1 + extra));
        rx_line = 1'b1;
        #(bit_ns);
    endtask
    task automatic glitch(input real ns);
        rx_line = 1'b0;
        #(ns);
        rx_line = 1'b1;
    endtask
    always @(negedge tx_line) t_fall = $realtime;
    always @(posedge tx_line) low_ns = $realtime - t_fall;
    always begin : decode
        logic [8:0] w;
        @(negedge tx_line);
        #(bit_ns * 1.5);
        for (int i = 0; i < 8; i++) begin
            w[i] = tx_line;
            #(bit_ns);
        end
        w[8] = 1'b0;
        if (nine) begin
            w[8] = tx_line;
            #(bit_ns);
        end
        got_stop = tx_line;
        got_q.push_back(w);
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench of the second serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic ext_en = 1'b0, nine = 1'b0, rx_line, tx_line;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata;
    int fail_count = 0, num_checks = 0, cycles = 0;
    u2_uart dut (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .extended_uart_enable(ext_en),
        .serial_receive_pin(rx_line), .sfr_rdata(rdata), .serial_transmit_pin(tx_line));
    u2_remote far (.tx_line(tx_line), .nine(nine), .rx_line(rx_line));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm,
        input logic [7:0] m = 8'hFF);
        @(posedge clk);
        #1 {sfr_addr, sfr_rd} = {a, 1'b1};
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        `CHK(nm, e, rdata & m)
    endtask
    task automatic wait_q(input int n);
        for (int i = 0; i < 30000 && far.got_q.size() < n; i++) @(posedge clk);
    endtask
    task automatic t_regs();
        rd(8'hE1, 8'h00, "ctl rst");
        rd(8'hEB, 8'h00, "data rst");
        rd(8'hEE, 8'h00, "baud rst");
        rd(8'hE2, 8'h00, "unmapped");
        @(posedge clk);
        #1 clk_en = 1'b0;
        repeat (3) @(posedge clk);
        #1 clk_en = 1'b1;
        wr(8'hEE, 8'hFF);
        rd(8'hEE, 8'hBF, "baud rw");
        wr(8'hE1, 8'hFC);
        rd(8'hE1, 8'h44, "ctl rw");
        $display("regs done");
    endtask
    task automatic t_baud();
        logic [7:0] cfg[5] = '{8'h00, 8'h21, 8'h09, 8'h07, 8'h18};
        real clks[5] = '{17.75, 53.5, 71.0, 2272.0, 142.0};
        real err;
        wr(8'hE1, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(8'hEE, cfg[i]);
            far.bit_ns = clks[i] * 25.0;
            far.got_q.delete();
            wr(8'hEB, 8'h00);
            wait_q(1);
            // one tick of phase slack at each edge of the low run
            err = far.low_ns - 9.0 * far.bit_ns;
            err = err < 0.0 ? -err : err;
            `CHK("bit time", 1'b1, err < clks[i] * 3.2 + 25.0)
            rd(8'hE1, 8'h02, "tx flag");
            wr(8'hE1, 8'h00);
        end
        wr(8'hEE, 8'h00);
        far.bit_ns = 443.75;
        $display("baud done");
    endtask
    task automatic t_duplex();
        wr(8'hE1, 8'h04);
        far.got_q.delete();
        fork
            far.send(8'h96, 1'b0, 1'b1, 0);
            wr(8'hEB, 8'hA5);
        join
        wait_q(1);
        `CHK("tx byte", 9'h0A5, far.got_q[0])
        rd(8'hE1, 8'h07, "flags");
        rd(8'hEB, 8'h96, "rx byte");
        rd(8'hEE, 8'h40, "stop kept");
        ext_en = 1'b1;
        far.send(8'h5A, 1'b0, 1'b1, 0);
        rd(8'hE1, 8'h27, "overwrite");
        rd(8'hEB, 8'h5A, "rx new");
        wr(8'hE1, 8'h04);
        rd(8'hE1, 8'h04, "cleared");
        ext_en = 1'b0;
        far.send(8'h11, 1'b0, 1'b1, 0);
        far.send(8'h22, 1'b0, 1'b1, 0);
        rd(8'hEB, 8'h11, "kept byte");
        $display("duplex done");
    endtask
    task automatic t_errors();
        ext_en = 1'b1;
        far.send(8'h55, 1'b0, 1'b0, 0);
        rd(8'hE1, 8'h10, "frame err", 8'h18);
        rd(8'hEE, 8'h00, "bad stop", 8'h40);
        far.send(8'h00, 1'b0, 1'b0, 2);
        rd(8'hE1, 8'h18, "break", 8'h18);
        far.send(8'h55, 1'b0, 1'b1, 0);
        rd(8'hE1, 8'h00, "err gone", 8'h18);
        wr(8'hE1, 8'h00);
        far.send(8'h77, 1'b0, 1'b1, 0);
        rd(8'hE1, 8'h00, "rx off", 8'h01);
        rd(8'hEB, 8'h55, "rx off data");
        wr(8'hE1, 8'h04);
        far.glitch(150.0);
        repeat (300) @(posedge clk);
        rd(8'hE1, 8'h00, "glitch", 8'h01);
        $display("errors done");
    endtask
    task automatic t_nine();
        nine = 1'b1;
        wr(8'hE1, 8'h44);
        wr(8'hEE, 8'h80);
        far.got_q.delete();
        fork
            far.send(8'hC3, 1'b0, 1'b1, 0);
            wr(8'hEB, 8'h3C);
        join
        wait_q(1);
        `CHK("tx ninth", 9'h13C, far.got_q[0])
        `CHK("tx stop", 1'b1, far.got_stop)
        rd(8'hEB, 8'hC3, "rx nine");
        rd(8'hEE, 8'h80, "rx ninth", 8'hC0);
        nine = 1'b0;
        wr(8'hE1, 8'h04);
        $display("nine done");
    endtask
    task automatic t_buffer();
        // let the last stop bit end so the shifter is idle at the first write
        repeat (40) @(posedge clk);
        far.got_q.delete();
        wr(8'hEB, 8'h11);
        wr(8'hEB, 8'h22);
        wr(8'hEB, 8'h33);
        wr(8'hEB, 8'h44);
        wait_q(3);
        repeat (400) @(posedge clk);
        `CHK("queued", 3, far.got_q.size())
        `CHK("last", 9'h033, far.got_q[2])
        $display("buffer done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        t_regs();
        t_baud();
        t_duplex();
        t_errors();
        t_nine();
        t_buffer();
        give_verdict();
    end
endmodule
bind u2_uart u2_chk chk (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .extended_uart_enable(extended_uart_enable), .serial_receive_pin(serial_receive_pin),
    .sfr_rdata(sfr_rdata), .serial_transmit_pin(serial_transmit_pin));
`default_nettype wire
